// >>> design/config_mac_eeprom_regs.sv
/*
  Chip strap configuration, host MAC address and serial ROM pin control
  registers, with the reset-time MAC load from an external serial ROM.
  Assumes a 16-bit register port (word access, byte address) and strap
  pins held steady by the board around reset.
*/
// Summary of operation
// - Endian strap latched into configuration bit 10 after reset; 1 = little endian.
// - ROM presence strap latched into configuration bit 9; 1 = ROM fitted.
// - Configuration bit 7 reads 1 when the bus-width strap selects 8-bit mode.
// - Configuration bit 6 reads 1 when the same strap selects 16-bit mode.
// - Configuration bit 4 always reads 1: shared data and address bus.
// - With a ROM present, MAC words load from ROM words starting at 0x1.
// - ROM words 0x1, 0x2, 0x3 go to low, middle and high address registers.
// - Address registers are software readable and writable; ROM never rewritten.
// - Control bit 4 hands ROM pins to software via bits 3:0.
// - Write-only bit 5 picks software direction, 1 write; only when enabled.
// - Reading control bit 3 returns the current ROM data pin level.
// - Control bit 2 drives the ROM data pin.
// - Control bit 1 drives the ROM serial clock pin.
// - Control bit 0 drives the ROM chip-select pin.
`timescale 1ns/1ps
`include "config_mac_eeprom_consts.svh"

module config_mac_eeprom_regs
  import config_mac_eeprom_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // register port
  input  wire logic [11:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  // strap pins
  input  wire logic        endian_strap_pin,
  input  wire logic        rom_presence_strap_pin,
  input  wire logic        bus_width_strap_pin,
  // serial rom pins
  output logic             rom_select_pin,
  output logic             rom_clock_pin,
  input  wire logic        rom_data_pin_i,
  output logic             rom_data_pin_o,
  output logic             rom_data_pin_oe,
  // address to the rest of the device
  output logic      [47:0] host_mac_addr
);

  localparam int PIN_ENDIAN   = 0;
  localparam int PIN_PRESENCE = 1;
  localparam int PIN_BUS8     = 2;
  localparam int PIN_DIN      = 3;

  regs_state_t st_reg;
  regs_state_t st_next;

  logic        ld_busy;
  logic        ld_sel;
  logic        ld_sclk;
  logic        ld_dout;
  logic        ld_oe;
  logic        ld_valid;
  logic [1:0]  ld_idx;
  logic [15:0] ld_data;
  logic [3:0]  pins_raw;

  function automatic logic hit(input logic [11:0] addr, input logic [11:0] ofs);
    hit = (addr[11:1] == ofs[11:1]);
  endfunction

  function automatic logic [15:0] strap_word(input regs_state_t s);
    logic [15:0] w;
    w = `CHIP_STRAP_FIXED;
    w[`BIT_ENDIAN]       = s.strap_endian;
    w[`BIT_ROM_PRESENCE] = s.strap_presence;
    w[`BIT_BUS8]         = s.strap_bus8;
    w[`BIT_BUS16]        = ~s.strap_bus8;
    strap_word = w;
  endfunction

  function automatic logic [15:0] ctrl_word(input regs_state_t s);
    logic [15:0] w;
    w = 16'h0000;
    w[`BIT_SW_ENABLE] = s.ctrl_en;
    w[`BIT_DATA_IN]   = s.pin_level[PIN_DIN];
    w[`BIT_DATA_OUT]  = s.ctrl_dout;
    w[`BIT_CLOCK]     = s.ctrl_clk;
    w[`BIT_SELECT]    = s.ctrl_sel;
    ctrl_word = w;
  endfunction

  assign pins_raw = {rom_data_pin_i, bus_width_strap_pin,
                     rom_presence_strap_pin, endian_strap_pin};

  always_comb begin
    st_next = st_reg;
    st_next.load_start = 1'b0;
    // three-stage pin synchroniser; a level counts once stages two and three agree
    st_next.pin_sync[0] = pins_raw;
    st_next.pin_sync[1] = st_reg.pin_sync[0];
    st_next.pin_sync[2] = st_reg.pin_sync[1];
    for (int i = 0; i < 4; i++) begin
      if (st_reg.pin_sync[1][i] == st_reg.pin_sync[2][i]) begin
        st_next.pin_level[i] = st_reg.pin_sync[2][i];
      end
    end
    // straps are caught once after reset release, when the synchroniser is full
    if (!st_reg.captured) begin
      if (st_reg.settle_cnt == `STRAP_SETTLE_CYCLES) begin
        st_next.captured       = 1'b1;
        st_next.strap_endian   = st_reg.pin_level[PIN_ENDIAN];
        st_next.strap_presence = st_reg.pin_level[PIN_PRESENCE];
        st_next.strap_bus8     = st_reg.pin_level[PIN_BUS8];
        st_next.load_start     = st_reg.pin_level[PIN_PRESENCE];
      end else begin
        st_next.settle_cnt = st_reg.settle_cnt + 3'h1;
      end
    end
    // loader words land first so a same-cycle software write wins
    if (ld_valid) begin
      st_next.mac[ld_idx] = ld_data;
    end
    if (reg_wr) begin
      if (hit(reg_addr, `OFS_HOST_MAC_ADDR_LOW)) begin
        st_next.mac[0] = reg_wdata;
      end
      if (hit(reg_addr, `OFS_HOST_MAC_ADDR_MID)) begin
        st_next.mac[1] = reg_wdata;
      end
      if (hit(reg_addr, `OFS_HOST_MAC_ADDR_HIGH)) begin
        st_next.mac[2] = reg_wdata;
      end
      if (hit(reg_addr, `OFS_SERIAL_ROM_PIN_CTRL)) begin
        st_next.ctrl_dir  = reg_wdata[`BIT_SW_DIRECTION];
        st_next.ctrl_en   = reg_wdata[`BIT_SW_ENABLE];
        st_next.ctrl_dout = reg_wdata[`BIT_DATA_OUT];
        st_next.ctrl_clk  = reg_wdata[`BIT_CLOCK];
        st_next.ctrl_sel  = reg_wdata[`BIT_SELECT];
      end
    end
    // read data is registered and holds until the next read
    if (reg_rd) begin
      if (hit(reg_addr, `OFS_CHIP_STRAP_CONFIG)) begin
        st_next.rdata = strap_word(st_reg);
      end else if (hit(reg_addr, `OFS_HOST_MAC_ADDR_LOW)) begin
        st_next.rdata = st_reg.mac[0];
      end else if (hit(reg_addr, `OFS_HOST_MAC_ADDR_MID)) begin
        st_next.rdata = st_reg.mac[1];
      end else if (hit(reg_addr, `OFS_HOST_MAC_ADDR_HIGH)) begin
        st_next.rdata = st_reg.mac[2];
      end else if (hit(reg_addr, `OFS_SERIAL_ROM_PIN_CTRL)) begin
        st_next.rdata = ctrl_word(st_reg);
      end else begin
        st_next.rdata = 16'h0000;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  rom_mac_loader u_loader (
    .core_clk   (core_clk),
    .srst       (srst),
    .start      (st_reg.load_start),
    .busy       (ld_busy),
    .rom_din    (st_reg.pin_level[PIN_DIN]),
    .rom_sel    (ld_sel),
    .rom_sclk   (ld_sclk),
    .rom_dout   (ld_dout),
    .rom_oe     (ld_oe),
    .word_valid (ld_valid),
    .word_idx   (ld_idx),
    .word_data  (ld_data)
  );

  // pin ownership: software when enabled, loader otherwise
  assign rom_select_pin  = st_reg.ctrl_en ? st_reg.ctrl_sel : ld_sel;
  assign rom_clock_pin   = st_reg.ctrl_en ? st_reg.ctrl_clk : ld_sclk;
  assign rom_data_pin_o  = st_reg.ctrl_en ? st_reg.ctrl_dout : ld_dout;
  assign rom_data_pin_oe = st_reg.ctrl_en ? st_reg.ctrl_dir : ld_oe;
  assign reg_rdata       = st_reg.rdata;
  assign host_mac_addr   = {st_reg.mac[2], st_reg.mac[1], st_reg.mac[0]};

  AST_ENDIAN_CAPTURE: assert property (@(posedge core_clk) disable iff (srst)
    (!st_reg.captured && st_reg.settle_cnt == `STRAP_SETTLE_CYCLES)
    |=> st_reg.strap_endian == $past(st_reg.pin_level[PIN_ENDIAN]))
    else $error("endian strap not latched");

  AST_STRAPS_FROZEN: assert property (@(posedge core_clk) disable iff (srst)
    $past(st_reg.captured) |-> $stable(st_reg.strap_presence) && $stable(st_reg.strap_endian)
                               && $stable(st_reg.strap_bus8))
    else $error("strap value changed after capture");

  AST_BUS_WIDTH_READ: assert property (@(posedge core_clk) disable iff (srst)
    (reg_rd && hit(reg_addr, `OFS_CHIP_STRAP_CONFIG))
    |=> reg_rdata[`BIT_BUS8] == st_reg.strap_bus8
        && reg_rdata[`BIT_BUS16] == !st_reg.strap_bus8
        && reg_rdata[`BIT_ROM_PRESENCE] == st_reg.strap_presence)
    else $error("bus width bits wrong");

  AST_SHARED_BUS_ONE: assert property (@(posedge core_clk) disable iff (srst)
    (reg_rd && hit(reg_addr, `OFS_CHIP_STRAP_CONFIG))
    |=> reg_rdata[4] && reg_rdata[15:11] == 5'h00 && reg_rdata[3:0] == 4'h2)
    else $error("fixed configuration bits wrong");

  AST_LOAD_ONLY_WITH_ROM: assert property (@(posedge core_clk) disable iff (srst)
    $rose(ld_busy) |-> st_reg.strap_presence && $past(st_reg.load_start))
    else $error("loader started without rom present");

  AST_LOAD_MAP: assert property (@(posedge core_clk) disable iff (srst)
    (ld_valid && !reg_wr) |=> st_reg.mac[$past(ld_idx)] == $past(ld_data))
    else $error("loaded word landed in wrong register");

  AST_MAC_WRITE: assert property (@(posedge core_clk) disable iff (srst)
    (reg_wr && hit(reg_addr, `OFS_HOST_MAC_ADDR_MID))
    |=> ##1 (reg_rd && hit(reg_addr, `OFS_HOST_MAC_ADDR_MID) && !reg_wr
             && !ld_valid)[*1] |=> reg_rdata == $past(reg_wdata, 3))
    else $error("mac register readback differs from write");

  AST_SW_PINS: assert property (@(posedge core_clk) disable iff (srst)
    st_reg.ctrl_en |-> rom_select_pin == st_reg.ctrl_sel
                       && rom_clock_pin == st_reg.ctrl_clk
                       && rom_data_pin_o == st_reg.ctrl_dout)
    else $error("software pin values not driven");

  AST_DIRECTION: assert property (@(posedge core_clk) disable iff (srst)
    (reg_wr && hit(reg_addr, `OFS_SERIAL_ROM_PIN_CTRL) && reg_wdata[`BIT_SW_ENABLE])
    |=> rom_data_pin_oe == $past(reg_wdata[`BIT_SW_DIRECTION]))
    else $error("data pin direction not as written");

  AST_DIR_WRITE_ONLY: assert property (@(posedge core_clk) disable iff (srst)
    (reg_rd && hit(reg_addr, `OFS_SERIAL_ROM_PIN_CTRL))
    |=> reg_rdata[15:5] == 11'h000)
    else $error("write-only direction bit read back");

  AST_DATA_LEVEL: assert property (@(posedge core_clk) disable iff (srst)
    (reg_rd && hit(reg_addr, `OFS_SERIAL_ROM_PIN_CTRL))
    |=> reg_rdata[`BIT_DATA_IN] == $past(st_reg.pin_level[PIN_DIN]))
    else $error("data pin level misreported");

  AST_CTRL_WRITE_PINS: assert property (@(posedge core_clk) disable iff (srst)
    (reg_wr && hit(reg_addr, `OFS_SERIAL_ROM_PIN_CTRL) && reg_wdata[`BIT_SW_ENABLE])
    |=> rom_data_pin_o == $past(reg_wdata[`BIT_DATA_OUT])
        && rom_clock_pin == $past(reg_wdata[`BIT_CLOCK])
        && rom_select_pin == $past(reg_wdata[`BIT_SELECT]))
    else $error("written control bits not on pins");

  AST_LOADER_OWNS: assert property (@(posedge core_clk) disable iff (srst)
    !st_reg.ctrl_en |-> rom_select_pin == ld_sel && rom_clock_pin == ld_sclk
                        && rom_data_pin_oe == ld_oe)
    else $error("loader does not own rom pins");

endmodule

// >>> design/rom_mac_loader.sv
/*
  Reset-time serial ROM reader: fetches three consecutive 16-bit words
  starting at the first MAC word and presents each with a one-cycle valid.
  Assumes the data-in level is already synchronised to core_clk.
*/
`timescale 1ns/1ps
`include "config_mac_eeprom_consts.svh"

module rom_mac_loader
  import config_mac_eeprom_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // control
  input  wire logic        start,
  output logic             busy,
  // rom pins
  input  wire logic        rom_din,
  output logic             rom_sel,
  output logic             rom_sclk,
  output logic             rom_dout,
  output logic             rom_oe,
  // loaded words
  output logic             word_valid,
  output logic [1:0]       word_idx,
  output logic [15:0]      word_data
);

  localparam logic [3:0] HALF_LAST = 4'(`ROM_HALF_CYCLES - 1);

  loader_reg_t st_reg;
  loader_reg_t st_next;
  logic        tick;

  function automatic logic [15:0] read_cmd(input logic [1:0] idx);
    read_cmd = {`ROM_READ_CMD, `ROM_MAC_FIRST_WORD + {4'h0, idx}, 7'h00};
  endfunction

  assign tick = (st_reg.tick_cnt == HALF_LAST);

  always_comb begin
    st_next = st_reg;
    st_next.word_valid = 1'b0;
    if (st_reg.state != LD_IDLE) begin
      st_next.tick_cnt = tick ? 4'h0 : st_reg.tick_cnt + 4'h1;
    end
    case (st_reg.state)
      LD_IDLE: begin
        if (start) begin
          st_next.state    = LD_SELECT;
          st_next.word_idx = 2'h0;
          st_next.tick_cnt = 4'h0;
          st_next.bit_cnt  = 5'h00;
          st_next.sel      = 1'b1;
          st_next.shift    = read_cmd(2'h0);
        end
      end
      LD_SELECT: begin
        if (tick) begin
          st_next.state = LD_RISE;
        end
      end
      LD_RISE: begin
        if (tick) begin
          st_next.sclk  = 1'b1;
          st_next.state = LD_FALL;
        end
      end
      LD_FALL: begin
        if (tick) begin
          st_next.sclk  = 1'b0;
          st_next.shift = {st_reg.shift[14:0], rom_din};
          if (st_reg.bit_cnt == `ROM_FRAME_BITS - 5'h01) begin
            st_next.state      = LD_DESELECT;
            st_next.sel        = 1'b0;
            st_next.word_valid = 1'b1;
          end else begin
            st_next.bit_cnt = st_reg.bit_cnt + 5'h01;
            st_next.state   = LD_RISE;
          end
        end
      end
      LD_DESELECT: begin
        if (tick) begin
          if (st_reg.word_idx == `MAC_LAST_WORD) begin
            st_next.state = LD_IDLE;
          end else begin
            st_next.word_idx = st_reg.word_idx + 2'h1;
            st_next.bit_cnt  = 5'h00;
            st_next.sel      = 1'b1;
            st_next.shift    = read_cmd(st_reg.word_idx + 2'h1);
            st_next.state    = LD_SELECT;
          end
        end
      end
      default: begin
        st_next.state = LD_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign busy       = (st_reg.state != LD_IDLE);
  assign rom_sel    = st_reg.sel;
  assign rom_sclk   = st_reg.sclk;
  assign rom_dout   = st_reg.shift[15];
  // drive the shared data pin only while command bits go out
  assign rom_oe     = st_reg.sel && (st_reg.bit_cnt < `ROM_CMD_BITS);
  assign word_valid = st_reg.word_valid;
  assign word_idx   = st_reg.word_idx;
  assign word_data  = st_reg.shift;

endmodule

// >>> inc/config_mac_eeprom_consts.svh
/*
  Constants for the strap configuration, host MAC address and serial ROM
  control registers: byte offsets, bit positions, fixed values and timing.
  Assumes a 10 MHz core clock and a three-wire serial ROM read protocol.
*/
`ifndef CONFIG_MAC_EEPROM_CONSTS_SVH
`define CONFIG_MAC_EEPROM_CONSTS_SVH

// register byte offsets
`define OFS_CHIP_STRAP_CONFIG   12'h108
`define OFS_HOST_MAC_ADDR_LOW   12'h110
`define OFS_HOST_MAC_ADDR_MID   12'h112
`define OFS_HOST_MAC_ADDR_HIGH  12'h114
`define OFS_SERIAL_ROM_PIN_CTRL 12'h122

// chip_strap_config fields
`define BIT_ENDIAN        10
`define BIT_ROM_PRESENCE  9
`define BIT_BUS8          7
`define BIT_BUS16         6
`define CHIP_STRAP_FIXED  16'h0012

// serial_rom_pin_control fields
`define BIT_SW_DIRECTION  5
`define BIT_SW_ENABLE     4
`define BIT_DATA_IN       3
`define BIT_DATA_OUT      2
`define BIT_CLOCK         1
`define BIT_SELECT        0

// serial rom frame
`define ROM_MAC_FIRST_WORD 6'h01
`define ROM_READ_CMD       3'h6
`define ROM_CMD_BITS       5'h09
`define ROM_FRAME_BITS     5'h1a
`define MAC_LAST_WORD      2'h2

// timing
`define CLK_PERIOD_NS      100
`define ROM_HALF_PERIOD_NS 1000
`define ROM_HALF_CYCLES ((`ROM_HALF_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STRAP_SETTLE_CYCLES 3'h4

`endif

// >>> inc/config_mac_eeprom_pkg.sv
/*
  Types for the configuration / MAC address register bank and its serial
  ROM loader. Assumes the constants header is included by the modules.
*/
package config_mac_eeprom_pkg;

  typedef enum logic [2:0] {
    LD_IDLE     = 3'b000,
    LD_SELECT   = 3'b001,
    LD_RISE     = 3'b010,
    LD_FALL     = 3'b011,
    LD_DESELECT = 3'b100
  } loader_state_t;

  typedef struct packed {
    loader_state_t state;
    logic [3:0]    tick_cnt;
    logic [4:0]    bit_cnt;
    logic [1:0]    word_idx;
    logic [15:0]   shift;
    logic          sel;
    logic          sclk;
    logic          word_valid;
  } loader_reg_t;

  typedef struct packed {
    logic [2:0][3:0]  pin_sync;
    logic [3:0]       pin_level;
    logic [2:0]       settle_cnt;
    logic             captured;
    logic             strap_endian;
    logic             strap_presence;
    logic             strap_bus8;
    logic             load_start;
    logic [2:0][15:0] mac;
    logic             ctrl_dir;
    logic             ctrl_en;
    logic             ctrl_dout;
    logic             ctrl_clk;
    logic             ctrl_sel;
    logic [15:0]      rdata;
  } regs_state_t;

endpackage

// >>> testbench/serial_rom_model.sv
/*
  Behavioural serial ROM on the far side of the MAC loader pins.
  Assumes the bench resolves the shared data line and feeds wire_level.
*/
`timescale 1ns/1ps

module serial_rom_model (
  // pins from the device
  input  wire logic rom_select_pin,
  input  wire logic rom_clock_pin,
  input  wire logic wire_level,
  // line drive and bookkeeping
  output logic      rom_q,
  output int        frames,
  output int        bad_frames
);
  logic [15:0] mem [0:63];
  logic [8:0]  cmd;
  int          cnt;

  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i] = 16'hffff;
    end
    mem[1] = 16'h89ab;
    mem[2] = 16'h4567;
    mem[3] = 16'h0123;
    rom_q = 1'b0;
    frames = 0;
    bad_frames = 0;
    // no select rise seen yet: the first X-to-0 settle of the pin is no frame
    cnt = -1;
    cmd = 9'h000;
  end

  always @(posedge rom_select_pin) begin
    cnt = 0;
  end

  // a load frame is 26 clocks carrying a read of the next address word
  always @(negedge rom_select_pin) begin
    if (cnt >= 0) begin
      frames = frames + 1;
      if (cnt != 26 || cmd[8:6] !== 3'b110 || cmd[5:0] !== 6'(frames)) begin
        bad_frames = bad_frames + 1;
      end
      // released line shows the inverse of the last bit
      rom_q = ~rom_q;
    end
  end

  always @(posedge rom_clock_pin) begin
    if (rom_select_pin) begin
      if (cnt < 9) begin
        cmd = {cmd[7:0], wire_level};
      end else if (cnt == 9) begin
        rom_q = 1'b0;
      end else if (cnt < 26) begin
        rom_q = mem[cmd[5:0]][25 - cnt];
      end
      cnt = cnt + 1;
    end
  end
endmodule

// >>> testbench/tb_top.sv
/*
  Self-checking bench for the strap, MAC address and ROM control registers.
  Assumes the serial ROM model on the pins and the strobe register port.
*/
`timescale 1ns/1ps

`define CHK(what, exp, got) \
  begin \
    check_count++; \
    if ((got) !== (exp)) begin \
      miscompares++; \
      $display("BAD %s expected %h seen %h", what, exp, got); \
    end \
  end

module tb_top;
  localparam logic [11:0] strap_ofs    = 12'h108;
  localparam logic [11:0] low_ofs      = 12'h110;
  localparam logic [11:0] mid_ofs      = 12'h112;
  localparam logic [11:0] high_ofs     = 12'h114;
  localparam logic [11:0] ctrl_ofs     = 12'h122;
  localparam int          watch_cycles = 8000;

  logic        core_clk;
  logic        srst;
  logic [11:0] reg_addr;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic        endian_strap_pin;
  logic        rom_presence_strap_pin;
  logic        bus_width_strap_pin;
  logic        rom_select_pin;
  logic        rom_clock_pin;
  logic        rom_data_pin_o;
  logic        rom_data_pin_oe;
  logic [47:0] host_mac_addr;
  logic        wire_level;
  logic        rom_q;
  int          frames;
  int          bad_frames;
  int          miscompares;
  int          check_count;
  int          f0;

  always #50 core_clk = ~core_clk;

  // shared data line: device wins while it drives
  assign wire_level = rom_data_pin_oe ? rom_data_pin_o : rom_q;

  config_mac_eeprom_regs config_mac_eeprom_regs_i (
    .core_clk               (core_clk),
    .srst                   (srst),
    .reg_addr               (reg_addr),
    .reg_wr                 (reg_wr),
    .reg_rd                 (reg_rd),
    .reg_wdata              (reg_wdata),
    .reg_rdata              (reg_rdata),
    .endian_strap_pin       (endian_strap_pin),
    .rom_presence_strap_pin (rom_presence_strap_pin),
    .bus_width_strap_pin    (bus_width_strap_pin),
    .rom_select_pin         (rom_select_pin),
    .rom_clock_pin          (rom_clock_pin),
    .rom_data_pin_i         (wire_level),
    .rom_data_pin_o         (rom_data_pin_o),
    .rom_data_pin_oe        (rom_data_pin_oe),
    .host_mac_addr          (host_mac_addr)
  );

  serial_rom_model serial_rom_model_i (
    .rom_select_pin (rom_select_pin),
    .rom_clock_pin  (rom_clock_pin),
    .wire_level     (wire_level),
    .rom_q          (rom_q),
    .frames         (frames),
    .bad_frames     (bad_frames)
  );

  task automatic write_reg(input logic [11:0] a, input logic [15:0] d);
    @(negedge core_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge core_clk);
    reg_wr    = 1'b0;
  endtask

  task automatic read_chk(input logic [11:0] a, input logic [15:0] exp, input string what);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge core_clk);
    reg_rd   = 1'b0;
    @(negedge core_clk);
    `CHK(what, exp, reg_rdata)
  endtask

  // lets pins and the three-flop data synchroniser settle
  task automatic pin_chk(input logic [3:0] exp, input string what);
    repeat (5) @(negedge core_clk);
    `CHK(what, exp, {rom_data_pin_oe, rom_data_pin_o, rom_clock_pin, rom_select_pin})
  endtask

  task automatic wait_frames(input int target);
    int n;
    n = 0;
    while (frames < target && n < 3000) begin
      @(negedge core_clk);
      n++;
    end
    `CHK("rom frames", target, frames)
    repeat (40) @(negedge core_clk);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #(watch_cycles * 100);
    miscompares++;
    test_done();
  end

  initial begin
    core_clk = 1'b0;
    srst = 1'b1;
    reg_addr = 12'h000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
    miscompares = 0;
    check_count = 0;
    endian_strap_pin = 1'b1;
    rom_presence_strap_pin = 1'b1;
    bus_width_strap_pin = 1'b1;
    pin_chk(4'h0, "reset pins");
    @(negedge core_clk);
    srst = 1'b0;

    wait_frames(3);
    `CHK("bad frames", 0, bad_frames)
    read_chk(strap_ofs, 16'h0692, "strap cfg");
    read_chk(low_ofs, 16'h89ab, "mac low");
    read_chk(mid_ofs, 16'h4567, "mac mid");
    read_chk(high_ofs, 16'h0123, "mac high");
    `CHK("mac out", 48'h0123_4567_89ab, host_mac_addr)
    $display("test rom load done");

    f0 = frames;
    write_reg(low_ofs, 16'h1357);
    write_reg(mid_ofs, 16'h2468);
    write_reg(high_ofs, 16'hace0);
    write_reg(strap_ofs, 16'hffff);
    write_reg(12'h116, 16'hbeef);
    read_chk(low_ofs, 16'h1357, "mac low");
    read_chk(mid_ofs, 16'h2468, "mac mid");
    read_chk(high_ofs, 16'hace0, "mac high");
    read_chk(strap_ofs, 16'h0692, "strap kept");
    read_chk(12'h116, 16'h0000, "unmapped");
    `CHK("mac out", 48'hace0_2468_1357, host_mac_addr)
    `CHK("rom untouched", f0, frames)
    $display("test software mac done");

    for (int b = 0; b < 3; b++) begin
      write_reg(ctrl_ofs, 16'h0010 | (16'h0001 << b));
      pin_chk(4'h1 << b, "sw pin");
    end
    read_chk(ctrl_ofs, {11'h000, 1'b1, rom_q, 3'b100}, "ctrl read dir");
    write_reg(ctrl_ofs, 16'h0037);
    pin_chk(4'hf, "sw write pins");
    read_chk(ctrl_ofs, 16'h001f, "ctrl write dir");
    write_reg(ctrl_ofs, 16'h0027);
    pin_chk(4'h0, "loader pins");
    read_chk(ctrl_ofs, {12'h000, rom_q, 3'b111}, "ctrl off");
    $display("test pin control done");

    f0 = frames;
    srst = 1'b1;
    endian_strap_pin = 1'b0;
    rom_presence_strap_pin = 1'b0;
    bus_width_strap_pin = 1'b0;
    repeat (6) @(negedge core_clk);
    srst = 1'b0;
    repeat (700) @(negedge core_clk);
    `CHK("no rom frames", f0, frames)
    read_chk(strap_ofs, 16'h0052, "strap none");
    read_chk(low_ofs, 16'h0000, "mac clear");
    write_reg(low_ofs, 16'h0a0b);
    read_chk(low_ofs, 16'h0a0b, "sw mac low");
    write_reg(mid_ofs, 16'h0c0d);
    read_chk(mid_ofs, 16'h0c0d, "sw mac mid");
    write_reg(high_ofs, 16'h0e0f);
    read_chk(high_ofs, 16'h0e0f, "sw mac high");
    @(negedge core_clk);
    `CHK("sw mac out", 48'h0e0f_0c0d_0a0b, host_mac_addr)
    $display("test no rom done");
    test_done();
  end
endmodule
